// ### core/pic_state_pkg.sv
// constants shared by the command issuer and the picture state loader
package pic_state_pkg;
  localparam logic [2:0]  CMD_TYPE      = 3'h3;
  localparam logic [1:0]  CMD_PIPE      = 2'h2;
  localparam logic [2:0]  CMD_OPCODE    = 3'h4;
  localparam logic [7:0]  SUB_PIC_PARAM = 8'h00;
  localparam logic [15:0] PIC_LEN       = 16'h0004;
  localparam int          LEN_EXCLUDED  = 2;
  localparam int          PIC_DWORDS    = 8;
  localparam int          HDR_TYPE_LSB  = 29;
  localparam int          HDR_PIPE_LSB  = 27;
  localparam int          HDR_OP_LSB    = 24;
  localparam int          HDR_SUB_LSB   = 16;
  localparam int          AREA_WIDTH    = 15;
  localparam int          ROWS_LSB      = 16;
  localparam int          COLS_LSB      = 0;
  localparam int          CR_QP_LSB     = 24;
  localparam int          CB_QP_LSB     = 16;
  localparam int          DEBLK_BIT     = 15;
  localparam int          IT_CMD_BIT    = 14;
  localparam int          IT_DATA_BIT   = 13;
  localparam int          MONO_PWT_BIT  = 12;
  localparam logic [31:0] DW3_MBZ_MASK  = 32'hE0E00800;
  localparam logic [31:0] DW1_MBZ_MASK  = 32'hFFFF8000;
  localparam logic [31:0] DW2_MBZ_MASK  = 32'hFF00FF00;
endpackage : pic_state_pkg

// ### core/cmd_link_if.sv
// command dword link between issuer and picture state loader
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
  logic        valid;
  logic        ready;
  logic [31:0] dword;
  modport issuer (output valid, output dword, input ready);
  modport loader (input valid, input dword, output ready);
endinterface : cmd_link_if
`default_nettype wire

// ### core/pic_state_loader.sv
// device end: parses picture parameter command and holds picture state
`timescale 1ns/1ps
`default_nettype none
module pic_state_loader (
  input  wire logic        mclk,
  input  wire logic        rstn,
  cmd_link_if.loader       link,
  output logic             pic_valid,
  output logic             pic_start,
  output logic             other_cmd,
  output logic [14:0]      frame_area_mbs,
  output logic [7:0]       frame_rows_mbs,
  output logic [7:0]       frame_cols_mbs,
  output logic signed [4:0] cr_qp_adjust,
  output logic signed [4:0] cb_qp_adjust,
  output logic             deblock_info_scan,
  output logic             it_cmd_scan,
  output logic             it_data_scan,
  output logic             mono_pwt_flag
);
  typedef enum logic [1:0] {IDLE, PIC_BODY, SKIP} st_e;

  st_e         st_ff, nxt_st;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0]  idx_ff, nxt_idx;
  logic [14:0] area_ff, nxt_area;
  logic [7:0]  rows_ff, nxt_rows, cols_ff, nxt_cols;
  logic [4:0]  cr_ff, nxt_cr, cb_ff, nxt_cb;
  logic [3:0]  flags_ff, nxt_flags;
  logic        valid_ff, nxt_valid;
  logic        start_ff, nxt_start, other_ff, nxt_other;
  logic        hdr_pic;
  logic [31:0] d;

  assign link.ready = 1'b1;
  assign d = link.dword;

  always_comb begin
    hdr_pic = (d[31:pic_state_pkg::HDR_TYPE_LSB] == pic_state_pkg::CMD_TYPE)
      && (d[28:pic_state_pkg::HDR_PIPE_LSB] == pic_state_pkg::CMD_PIPE)
      && (d[26:pic_state_pkg::HDR_OP_LSB] == pic_state_pkg::CMD_OPCODE)
      && (d[23:pic_state_pkg::HDR_SUB_LSB] == pic_state_pkg::SUB_PIC_PARAM);
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_idx   = idx_ff;
    nxt_area  = area_ff;
    nxt_rows  = rows_ff;
    nxt_cols  = cols_ff;
    nxt_cr    = cr_ff;
    nxt_cb    = cb_ff;
    nxt_flags = flags_ff;
    nxt_valid = valid_ff;
    nxt_start = 1'b0;
    nxt_other = 1'b0;
    if (link.valid) begin
      case (st_ff)
        IDLE: begin
          // every command but the picture command: length field plus the two excluded dwords
          nxt_cnt = d[15:0] + 16'(pic_state_pkg::LEN_EXCLUDED - 1);
          nxt_idx = 4'h1;
          if (hdr_pic) begin
            // fixed size: its length field would stop two dwords short
            nxt_cnt   = 16'(pic_state_pkg::PIC_DWORDS - 1);
            nxt_st    = PIC_BODY;
            nxt_valid = 1'b0; // picture boundary: old state retired
          end else begin
            nxt_st    = SKIP;
            nxt_other = 1'b1;
          end
        end
        PIC_BODY: begin
          case (idx_ff)
            4'h1: nxt_area = d[pic_state_pkg::AREA_WIDTH-1:0];
            4'h2: begin
              nxt_rows = d[pic_state_pkg::ROWS_LSB+:8];
              nxt_cols = d[pic_state_pkg::COLS_LSB+:8];
            end
            4'h3: begin
              nxt_cr = d[pic_state_pkg::CR_QP_LSB+:5];
              nxt_cb = d[pic_state_pkg::CB_QP_LSB+:5];
              nxt_flags = {d[pic_state_pkg::DEBLK_BIT],
                           d[pic_state_pkg::IT_CMD_BIT],
                           d[pic_state_pkg::IT_DATA_BIT],
                           d[pic_state_pkg::MONO_PWT_BIT]};
            end
            default: ;
          endcase
          nxt_idx = idx_ff + 4'h1;
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001) begin
            nxt_st    = IDLE;
            nxt_valid = 1'b1;
            nxt_start = 1'b1;
          end
        end
        SKIP: begin
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001) begin
            nxt_st = IDLE;
          end
        end
        default: nxt_st = IDLE;
      endcase
    end
  end

  // fields only move while a picture command is being taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= IDLE;
      cnt_ff   <= 16'h0000;
      idx_ff   <= 4'h0;
      area_ff  <= 15'h0000;
      rows_ff  <= 8'h00;
      cols_ff  <= 8'h00;
      cr_ff    <= 5'h00;
      cb_ff    <= 5'h00;
      flags_ff <= 4'h0;
      valid_ff <= 1'b0;
      start_ff <= 1'b0;
      other_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      idx_ff   <= nxt_idx;
      area_ff  <= nxt_area;
      rows_ff  <= nxt_rows;
      cols_ff  <= nxt_cols;
      cr_ff    <= nxt_cr;
      cb_ff    <= nxt_cb;
      flags_ff <= nxt_flags;
      valid_ff <= nxt_valid;
      start_ff <= nxt_start;
      other_ff <= nxt_other;
    end
  end

  assign pic_valid         = valid_ff;
  assign pic_start         = start_ff;
  assign other_cmd         = other_ff;
  assign frame_area_mbs    = area_ff;
  assign frame_rows_mbs    = rows_ff;
  assign frame_cols_mbs    = cols_ff;
  assign cr_qp_adjust      = cr_ff;
  assign cb_qp_adjust      = cb_ff;
  assign deblock_info_scan = flags_ff[3];
  assign it_cmd_scan       = flags_ff[2];
  assign it_data_scan      = flags_ff[1];
  assign mono_pwt_flag     = flags_ff[0];
endmodule : pic_state_loader
`default_nettype wire

// ### core/pic_cmd_issuer.sv
// issuer end: builds and sends the eight-dword picture parameter command
`timescale 1ns/1ps
`default_nettype none
module pic_cmd_issuer (
  input  wire logic        mclk,
  input  wire logic        rstn,
  cmd_link_if.issuer       link,
  input  wire logic        send,
  input  wire logic [7:0]  rows_mbs,
  input  wire logic [7:0]  cols_mbs,
  input  wire logic [4:0]  cr_adj,
  input  wire logic [4:0]  cb_adj,
  input  wire logic        deblock_scan,
  input  wire logic        it_cmd_scan,
  input  wire logic        it_data_scan,
  output logic             busy,
  output logic             done
);
  logic [31:0] dw_ff [pic_state_pkg::PIC_DWORDS];
  logic [31:0] nxt_dw [pic_state_pkg::PIC_DWORDS];
  logic [3:0]  idx_ff, nxt_idx;
  logic        busy_ff, nxt_busy, done_ff, nxt_done;
  logic [15:0] area;

  assign area = rows_mbs * cols_mbs;

  always_comb begin
    nxt_dw   = dw_ff;
    nxt_idx  = idx_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (!busy_ff && send) begin
      nxt_dw[0] = {pic_state_pkg::CMD_TYPE, pic_state_pkg::CMD_PIPE,
                   pic_state_pkg::CMD_OPCODE, pic_state_pkg::SUB_PIC_PARAM,
                   pic_state_pkg::PIC_LEN};
      // top area bit and reserved fields forced low
      nxt_dw[1] = {16'h0000, area} & ~pic_state_pkg::DW1_MBZ_MASK;
      nxt_dw[2] = {8'h00, rows_mbs, 8'h00, cols_mbs};
      nxt_dw[3] = ({3'h0, cr_adj, 3'h0, cb_adj, deblock_scan, it_cmd_scan,
                    it_data_scan, 1'b1, 12'h000})
                  & ~pic_state_pkg::DW3_MBZ_MASK;
      for (int i = 4; i < pic_state_pkg::PIC_DWORDS; i++) begin
        nxt_dw[i] = 32'h00000000;
      end
      nxt_idx  = 4'h0;
      nxt_busy = 1'b1;
    end else if (busy_ff && link.ready) begin
      nxt_idx = idx_ff + 4'h1;
      if (idx_ff == 4'(pic_state_pkg::PIC_DWORDS - 1)) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < pic_state_pkg::PIC_DWORDS; i++) begin
        dw_ff[i] <= 32'h00000000;
      end
      idx_ff  <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      dw_ff   <= nxt_dw;
      idx_ff  <= nxt_idx;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // picture command goes first; slice commands wait for done
  assign link.valid = busy_ff;
  assign link.dword = dw_ff[idx_ff[2:0]];
  assign busy       = busy_ff;
  assign done       = done_ff;
endmodule : pic_cmd_issuer
`default_nettype wire

// ### dv/pic_state_asserts.sv
// concurrent checks on the issuer to loader command link
`timescale 1ns/1ps
`default_nettype none
module pic_state_asserts (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              valid,
  input wire logic              ready,
  input wire logic [31:0]       dword,
  input wire logic              pic_valid,
  input wire logic              pic_start,
  input wire logic [14:0]       frame_area_mbs,
  input wire logic [7:0]        frame_rows_mbs,
  input wire logic [7:0]        frame_cols_mbs,
  input wire logic signed [4:0] cr_qp_adjust,
  input wire logic signed [4:0] cb_qp_adjust,
  input wire logic [3:0]        scan_flags
);
  // only picture commands cross this link, so a wrapping index suffices
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  always_comb begin
    nxt_idx = idx_ff;
    if (valid && ready) nxt_idx = idx_ff + 3'h1;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) idx_ff <= 3'h0;
    else idx_ff <= nxt_idx;
  end
  default clocking link_clk @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_take(int n);
    valid && ready && idx_ff == n;
  endsequence
  a_ready_always: assert property (ready)
    else $error("loader dropped ready");
  a_hdr_code: assert property (s_take(0) |->
    dword == {pic_state_pkg::CMD_TYPE, pic_state_pkg::CMD_PIPE,
              pic_state_pkg::CMD_OPCODE, pic_state_pkg::SUB_PIC_PARAM,
              pic_state_pkg::PIC_LEN})
    else $error("picture header code wrong");
  a_dw3_reserved: assert property (s_take(3) |->
    (dword & pic_state_pkg::DW3_MBZ_MASK) == 32'h00000000)
    else $error("reserved bits set in third body dword");
  a_start_at_end: assert property (s_take(7) |=> pic_start)
    else $error("no start after last dword");
  a_start_only_end: assert property (pic_start |->
    $past(valid && idx_ff == 3'h7))
    else $error("start without last dword");
  a_drop_at_hdr: assert property (s_take(0) |=> !pic_valid)
    else $error("state valid during header");
  a_area_from_dw: assert property (s_take(1) |=>
    frame_area_mbs == $past(dword[14:0]))
    else $error("area field wrong");
  a_size_from_dw: assert property (s_take(2) |=>
    {frame_rows_mbs, frame_cols_mbs} ==
    $past({dword[23:16], dword[7:0]}))
    else $error("rows or cols wrong");
  a_qp_from_dw: assert property (s_take(3) |=>
    {cr_qp_adjust, cb_qp_adjust} ==
    $past({dword[28:24], dword[20:16]}))
    else $error("qp adjust wrong");
  a_flags_from_dw: assert property (s_take(3) |=>
    scan_flags == $past(dword[15:12]))
    else $error("scan flags wrong");
  a_hold_idle: assert property (!valid |=> $stable({frame_area_mbs,
    frame_rows_mbs, frame_cols_mbs, cr_qp_adjust, cb_qp_adjust,
    scan_flags}))
    else $error("held state moved while idle");
endmodule : pic_state_asserts
`default_nettype wire

// ### dv/tb.sv
// testbench: issuer joined to loader, plus a loader fed directly
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  logic             send = 1'b0;
  logic [7:0]       rows = 8'h01;
  logic [7:0]       cols = 8'h01;
  logic [4:0]       cr = 5'h00;
  logic [4:0]       cb = 5'h00;
  logic [2:0]       scan = 3'h0;
  wire              busy, done, pv, ps, pv2, oc2;
  wire [14:0]       area, area2;
  wire [7:0]        r_o, c_o, r2, c2;
  wire signed [4:0] cr_o, cb_o;
  wire [3:0]        fl;
  int               errors = 0;
  int               check_count = 0;
  cmd_link_if lk ();
  cmd_link_if lk2 ();
  pic_cmd_issuer pic_cmd_issuer_inst (.mclk(mclk), .rstn(rstn),
    .link(lk.issuer), .send(send), .rows_mbs(rows), .cols_mbs(cols),
    .cr_adj(cr), .cb_adj(cb), .deblock_scan(scan[2]),
    .it_cmd_scan(scan[1]), .it_data_scan(scan[0]), .busy(busy),
    .done(done));
  pic_state_loader pic_state_loader_inst (.mclk(mclk), .rstn(rstn),
    .link(lk.loader), .pic_valid(pv), .pic_start(ps), .other_cmd(),
    .frame_area_mbs(area), .frame_rows_mbs(r_o), .frame_cols_mbs(c_o),
    .cr_qp_adjust(cr_o), .cb_qp_adjust(cb_o), .deblock_info_scan(fl[3]),
    .it_cmd_scan(fl[2]), .it_data_scan(fl[1]), .mono_pwt_flag(fl[0]));
  pic_state_loader pic_state_loader_inst2 (.mclk(mclk), .rstn(rstn),
    .link(lk2.loader), .pic_valid(pv2), .pic_start(), .other_cmd(oc2),
    .frame_area_mbs(area2), .frame_rows_mbs(r2), .frame_cols_mbs(c2),
    .cr_qp_adjust(), .cb_qp_adjust(), .deblock_info_scan(),
    .it_cmd_scan(), .it_data_scan(), .mono_pwt_flag());
  pic_state_asserts pic_state_asserts_inst (.mclk(mclk), .rstn(rstn),
    .valid(lk.valid), .ready(lk.ready), .dword(lk.dword), .pic_valid(pv),
    .pic_start(ps), .frame_area_mbs(area), .frame_rows_mbs(r_o),
    .frame_cols_mbs(c_o), .cr_qp_adjust(cr_o), .cb_qp_adjust(cb_o),
    .scan_flags(fl));
  always #5 mclk = ~mclk;
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk_pic(input logic [7:0] r, c, input logic [4:0] a, b,
                         input logic [2:0] s);
    logic [15:0] p;
    p = r * c;
    `CHK("area", p[14:0], area)
    `CHK("rows", r, r_o)
    `CHK("cols", c, c_o)
    `CHK("cr", a, cr_o)
    `CHK("cb", b, cb_o)
    `CHK("flags", {s, 1'b1}, fl)
    `CHK("valid", 1'b1, pv)
  endtask : chk_pic
  task automatic issue(input logic [7:0] r, c, input logic [4:0] a, b,
                       input logic [2:0] s);
    @(posedge mclk);
    {rows, cols, cr, cb, scan, send} <= {r, c, a, b, s, 1'b1};
    @(posedge mclk);
    send <= 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge mclk);
    `CHK("done", 1'b1, done)
    `CHK("start", 1'b1, ps)
    `CHK("busy", 1'b0, busy)
    chk_pic(r, c, a, b, s);
  endtask : issue
  task automatic t_bounds();
    // -12 and +12 offsets with the largest legal frame area
    issue(8'hFF, 8'h80, 5'h14, 5'h0C, 3'h5);
  endtask : t_bounds
  task automatic t_back();
    issue(8'h01, 8'h01, 5'h00, 5'h1F, 3'h2);
    issue(8'h44, 8'h78, 5'h0C, 5'h14, 3'h5);
    repeat (20) @(negedge mclk);
    chk_pic(8'h44, 8'h78, 5'h0C, 5'h14, 3'h5);
  endtask : t_back
  task automatic t_reset();
    @(posedge mclk);
    send <= 1'b1;
    repeat (4) @(posedge mclk);
    rstn <= 1'b0;
    send <= 1'b0;
    @(negedge mclk);
    `CHK("rst", 16'h0, {pv, area})
    `CHK("rst", 12'h0, {r_o, fl})
    @(posedge mclk);
    rstn <= 1'b1;
    issue(8'h02, 8'h03, 5'h01, 5'h1E, 3'h0);
  endtask : t_reset
  task automatic t_skip();
    // a foreign command whose body mimics a picture command
    logic [31:0] q[$] = '{32'h6D000002, 32'h74000004, 32'h00007FFF,
      32'h00FF00FF, 32'h74000004, 32'h00008006, 32'h00030002,
      32'h00001000, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (q[i]) begin
      @(posedge mclk);
      lk2.valid <= 1'b1;
      lk2.dword <= q[i];
      @(negedge mclk);
      if (i == 1) `CHK("other2", 1'b1, oc2)
      if (i == 2) `CHK("other2", 1'b0, oc2)
      if (i == 5) `CHK("other2", 1'b0, oc2)
    end
    @(posedge mclk);
    lk2.valid <= 1'b0;
    lk2.dword <= 32'hA5A5A5A5;
    @(negedge mclk);
    `CHK("area2", 15'h0006, area2)
    `CHK("size2", 16'h0302, {r2, c2})
    `CHK("valid2", 1'b1, pv2)
  endtask : t_skip
  initial begin
    lk2.valid = 1'b0;
    lk2.dword = 32'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_bounds();
    t_back();
    t_reset();
    t_skip();
    stop_test();
  end
  initial begin
    // tests need about 85 cycles
    #20000;
    errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
